// File: rtl/failsafe_pkg.sv
// Purpose: Shared constants, types and register map of the fail safe output bank
// Assumes: 125 MHz bus clock, AHB-Lite word-aligned register map
// Notes:   Every offset, field position and timing count lives here, and the reset values of the output, bitmap, type and delay registers
package failsafe_pkg;

   // Bank geometry
   localparam int unsigned POINTS    = 24;
   localparam int unsigned LANES     = 4;
   localparam int unsigned BYTE_W    = 8;

   // Timing: one delay unit is a tenth of a second
   localparam int unsigned CLK_HZ       = 125_000_000;
   localparam int unsigned TENTH_MS     = 100;
   localparam int unsigned TENTH_CYCLES = (CLK_HZ / 1000) * TENTH_MS;

   // Register byte offsets
   localparam logic [7:0] OFF_OUTPUT = 8'h00;
   localparam logic [7:0] OFF_BITMAP = 8'h04;
   localparam logic [7:0] OFF_SELECT = 8'h08;
   localparam logic [7:0] OFF_DELAY  = 8'h0C;
   localparam logic [7:0] OFF_COMMIT = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;

   // Status register field positions
   localparam int unsigned ST_DELAY_LSB = 0;
   localparam int unsigned ST_TYPE_LSB  = 8;
   localparam int unsigned ST_ALIVE_BIT = 16;
   localparam int unsigned ST_STATE_LSB = 24;

   // Fail safe type codes
   localparam logic [7:0] TYPE_OFF     = 8'h01;
   localparam logic [7:0] TYPE_PATTERN = 8'h02;
   localparam logic [7:0] TYPE_HOLD    = 8'h03;

   // Reset values
   localparam logic [POINTS-1:0] RST_POINTS = 24'h000000;
   localparam logic [7:0]        RST_TYPE   = 8'h01;
   localparam logic [7:0]        RST_DELAY  = 8'h00;
   localparam logic [31:0]       RST_RDATA  = 32'h0000_0000;

   // AHB encodings
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam logic       HRESP_OKAY = 1'b0;

   // Bank supervision states
   typedef enum logic [1:0] {
      ST_NORMAL,
      ST_WAIT,
      ST_SAFE
   } safe_state_t;

   // Captured address phase
   typedef struct packed {
      logic             wr;
      logic [7:0]       addr;
      logic [LANES-1:0] lanes;
   } bus_req_t;

endpackage : failsafe_pkg

// File: rtl/tenth_tick.sv
// Purpose: One-cycle enable pulse every tenth of a second
// Assumes: Single clock domain, clear restarts a full period
// Notes:   Period is a parameter so simulation can shorten it
`timescale 1ns/1ns
module tenth_tick #(
   parameter int unsigned CYCLES = failsafe_pkg::TENTH_CYCLES
) (
   input  wire logic clk,     // Bus clock
   input  wire logic rst_n,   // Async reset, active low
   input  wire logic clear,   // Restart the period
   output logic      tick     // One-cycle pulse at period end
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_q;

   // Free counter, restarted so the first pulse comes one whole period after clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (clear || cnt_q == LAST) begin
         cnt_q <= '0;
         tick  <= !clear;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule : tenth_tick

// File: rtl/lane_merge.sv
// Purpose: Merge AHB write data into a register by byte lane
// Assumes: Lane n carries bits 8n+7..8n of both bus data and register
// Notes:   Lanes above the register width are dropped
`timescale 1ns/1ns
module lane_merge #(
   parameter int unsigned W = 24
) (
   input  wire logic [W-1:0] old_val,   // Current register value
   input  wire logic [31:0]  wdata,     // Bus write data
   input  wire logic [3:0]   lanes,     // Active byte lanes
   output logic      [W-1:0] new_val    // Merged value
);
   // Bit i follows lane i/8, so bit i always maps to point i at any access width
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign new_val[i] = lanes[i / 8] ? wdata[i] : old_val[i];
   end
endmodule : lane_merge

// File: rtl/failsafe_outputs.sv
// Purpose: Digital output bank with communication-loss fail safe, AHB-Lite slave
// Assumes: link_alive pin is high while host traffic is seen; one clock hclk
// Notes:   Function
`timescale 1ns/1ns
module failsafe_outputs #(
   parameter int unsigned TENTH_CYCLES = failsafe_pkg::TENTH_CYCLES
) (
   input  wire logic                            hclk,        // Bus clock, 125 MHz
   input  wire logic                            hresetn,     // Async reset, active low
   input  wire logic                            hsel,        // Slave select
   input  wire logic [31:0]                     haddr,       // Byte address
   input  wire logic [1:0]                      htrans,      // Transfer type
   input  wire logic                            hwrite,      // Write when high
   input  wire logic [2:0]                      hsize,       // Transfer size
   input  wire logic [31:0]                     hwdata,      // Write data
   input  wire logic                            hready,      // Bus ready
   output logic      [31:0]                     hrdata,      // Read data
   output logic                                 hreadyout,   // Slave ready
   output logic                                 hresp,       // Always OKAY
   input  wire logic                            link_alive,  // Host link healthy, async pin
   output logic      [failsafe_pkg::POINTS-1:0] point_out    // Driven output points
);
   localparam int unsigned N = failsafe_pkg::POINTS;

   failsafe_pkg::bus_req_t    req_q;
   failsafe_pkg::safe_state_t state_q, state_d;
   logic                      rd_pend_q;
   logic [N-1:0]              output_q, stage_bitmap_q, act_bitmap_q;
   logic [7:0]                stage_type_q, stage_delay_q, act_type_q, act_delay_q;
   logic [7:0]                cnt_q, cnt_d;
   logic                      commit_q;
   logic                      sync1_q, sync2_q, sync3_q, alive_q;
   logic [N-1:0]              point_d;

   // Address phase decode and byte lanes
   wire       accept  = hsel && htrans[1] && hready;
   wire [3:0] lane_b  = 4'h1 << haddr[1:0];
   wire [3:0] lane_h  = haddr[1] ? 4'hC : 4'h3;
   wire [3:0] lanes_a = (hsize == failsafe_pkg::HSIZE_BYTE) ? lane_b :
                        (hsize == failsafe_pkg::HSIZE_HALF) ? lane_h : 4'hF;

   // Data phase write strobes, one per writable register
   wire wr_output = req_q.wr && req_q.addr == failsafe_pkg::OFF_OUTPUT;
   wire wr_bitmap = req_q.wr && req_q.addr == failsafe_pkg::OFF_BITMAP;
   wire wr_select = req_q.wr && req_q.addr == failsafe_pkg::OFF_SELECT && req_q.lanes[0];
   wire wr_delay  = req_q.wr && req_q.addr == failsafe_pkg::OFF_DELAY  && req_q.lanes[0];
   wire wr_commit = req_q.wr && req_q.addr == failsafe_pkg::OFF_COMMIT && req_q.lanes[0];

   // Lane merges for the point-wide registers
   logic [N-1:0] output_merged, bitmap_merged;

   lane_merge #(.W(N)) u_out_merge (
      .old_val (output_q),
      .wdata   (hwdata),
      .lanes   (req_q.lanes),
      .new_val (output_merged)
   );

   lane_merge #(.W(N)) u_map_merge (
      .old_val (stage_bitmap_q),
      .wdata   (hwdata),
      .lanes   (req_q.lanes),
      .new_val (bitmap_merged)
   );

   // Read mux; write-only registers read back as zero
   wire [31:0] status_word =
      (32'(act_delay_q) << failsafe_pkg::ST_DELAY_LSB) |
      (32'(act_type_q)  << failsafe_pkg::ST_TYPE_LSB)  |
      (32'(alive_q)     << failsafe_pkg::ST_ALIVE_BIT) |
      (32'(state_q)     << failsafe_pkg::ST_STATE_LSB);
   wire [31:0] rd_mux =
      (req_q.addr == failsafe_pkg::OFF_OUTPUT) ? 32'(output_q)    :
      (req_q.addr == failsafe_pkg::OFF_COMMIT) ? 32'(commit_q)    :
      (req_q.addr == failsafe_pkg::OFF_STATUS) ? status_word      :
      failsafe_pkg::RST_RDATA;

   // Bus handshake: reads take one wait state so hrdata is registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q     <= '0;
         rd_pend_q <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= failsafe_pkg::RST_RDATA;
         hresp     <= failsafe_pkg::HRESP_OKAY;
      end else begin
         req_q.wr  <= accept && hwrite;
         rd_pend_q <= accept && !hwrite;
         hreadyout <= !(accept && !hwrite);
         if (accept) begin
            req_q.addr  <= {haddr[7:2], 2'b00};
            req_q.lanes <= lanes_a;
         end
         if (rd_pend_q) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Host-written registers; staged values held apart from active ones
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_q       <= failsafe_pkg::RST_POINTS;
         stage_bitmap_q <= failsafe_pkg::RST_POINTS;
         stage_type_q   <= failsafe_pkg::RST_TYPE;
         stage_delay_q  <= failsafe_pkg::RST_DELAY;
      end else begin
         if (wr_output) output_q <= output_merged;
         if (wr_bitmap) stage_bitmap_q <= bitmap_merged;
         if (wr_select) stage_type_q <= hwdata[7:0];
         if (wr_delay)  stage_delay_q <= hwdata[7:0];
      end
   end

   // Commit flag: a true write sets it, the next edge transfers and clears it.
   // A fresh true write in the clearing cycle keeps it set so it is not lost.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         commit_q     <= 1'b0;
         act_bitmap_q <= failsafe_pkg::RST_POINTS;
         act_type_q   <= failsafe_pkg::RST_TYPE;
         act_delay_q  <= failsafe_pkg::RST_DELAY;
      end else begin
         commit_q <= wr_commit && hwdata[0];
         if (commit_q) begin
            act_bitmap_q <= stage_bitmap_q;
            act_type_q   <= stage_type_q;
            act_delay_q  <= stage_delay_q;
         end
      end
   end

   // Link pin: three stages, a change counts once stages two and three agree.
   // Stages reset to the healthy level so leaving reset never looks like a loss.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         sync3_q <= 1'b1;
         alive_q <= 1'b1;
      end else begin
         sync1_q <= link_alive;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) alive_q <= sync3_q;
      end
   end

   wire lost = !alive_q;

   // Tenth-second pacing, restarted whenever the delay is not running
   logic tick;

   tenth_tick #(.CYCLES(TENTH_CYCLES)) u_tick (
      .clk   (hclk),
      .rst_n (hresetn),
      .clear (state_q != failsafe_pkg::ST_WAIT),
      .tick  (tick)
   );

   // Supervision: delay runs from loss, safe action lands on all points at once
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         failsafe_pkg::ST_NORMAL: begin
            if (lost) begin
               cnt_d   = act_delay_q;
               state_d = (act_delay_q == 8'h00) ? failsafe_pkg::ST_SAFE
                                                : failsafe_pkg::ST_WAIT;
            end
         end
         failsafe_pkg::ST_WAIT: begin
            if (!lost) begin
               state_d = failsafe_pkg::ST_NORMAL;
            end else if (tick) begin
               cnt_d = cnt_q - 8'h01;
               if (cnt_q == 8'h01) state_d = failsafe_pkg::ST_SAFE;
            end
         end
         failsafe_pkg::ST_SAFE: begin
            if (!lost) state_d = failsafe_pkg::ST_NORMAL;
         end
         default: state_d = failsafe_pkg::ST_NORMAL;
      endcase
   end

   // Output selection; unknown type codes hold the last state as the least surprising
   always_comb begin
      point_d = output_q;
      if (state_q == failsafe_pkg::ST_SAFE) begin
         case (act_type_q)
            failsafe_pkg::TYPE_OFF:     point_d = '0;
            failsafe_pkg::TYPE_PATTERN: point_d = act_bitmap_q;
            failsafe_pkg::TYPE_HOLD:    point_d = point_out;
            default:                    point_d = point_out;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q   <= failsafe_pkg::ST_NORMAL;
         cnt_q     <= failsafe_pkg::RST_DELAY;
         point_out <= failsafe_pkg::RST_POINTS;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         point_out <= point_d;
      end
   end

   // Checks kept beside the logic they guard
   sequence s_commit_written;
      wr_commit && hwdata[0];
   endsequence

   sequence s_transferred;
      commit_q ##1 (!commit_q || $past(wr_commit && hwdata[0]));
   endsequence

   property p_commit_self_clear;
      @(posedge hclk) disable iff (!hresetn)
      s_commit_written |=> s_transferred;
   endproperty
   a_commit_self_clear: assert property (p_commit_self_clear)
      else $error("commit flag did not self clear after transfer");

   property p_commit_loads;
      @(posedge hclk) disable iff (!hresetn)
      commit_q |=> act_type_q == $past(stage_type_q) && act_delay_q == $past(stage_delay_q)
                   && act_bitmap_q == $past(stage_bitmap_q);
   endproperty
   a_commit_loads: assert property (p_commit_loads)
      else $error("staged settings not transferred on commit");

   property p_staged_hold;
      @(posedge hclk) disable iff (!hresetn)
      !commit_q |=> $stable(act_type_q) && $stable(act_delay_q) && $stable(act_bitmap_q);
   endproperty
   a_staged_hold: assert property (p_staged_hold)
      else $error("active settings changed without commit");

   property p_write_false;
      @(posedge hclk) disable iff (!hresetn)
      wr_commit && !hwdata[0] |=> !commit_q;
   endproperty
   a_write_false: assert property (p_write_false)
      else $error("false write to commit had an effect");

   property p_zero_delay;
      @(posedge hclk) disable iff (!hresetn)
      state_q == failsafe_pkg::ST_NORMAL && lost && act_delay_q == 8'h00
         |=> state_q == failsafe_pkg::ST_SAFE;
   endproperty
   a_zero_delay: assert property (p_zero_delay)
      else $error("zero delay did not enter fail safe at once");

   property p_delay_expiry;
      @(posedge hclk) disable iff (!hresetn)
      state_q == failsafe_pkg::ST_WAIT && lost && tick && cnt_q == 8'h01
         |=> state_q == failsafe_pkg::ST_SAFE
             ##1 (act_type_q != failsafe_pkg::TYPE_OFF || point_out == '0);
   endproperty
   a_delay_expiry: assert property (p_delay_expiry)
      else $error("fail safe not entered at delay expiry");

   property p_all_off;
      @(posedge hclk) disable iff (!hresetn)
      state_q == failsafe_pkg::ST_SAFE && act_type_q == failsafe_pkg::TYPE_OFF
         |=> point_out == '0;
   endproperty
   a_all_off: assert property (p_all_off)
      else $error("all-off fail safe left a point on");

   property p_pattern;
      @(posedge hclk) disable iff (!hresetn)
      state_q == failsafe_pkg::ST_SAFE && act_type_q == failsafe_pkg::TYPE_PATTERN
         |=> point_out == $past(act_bitmap_q);
   endproperty
   a_pattern: assert property (p_pattern)
      else $error("pattern fail safe does not follow bitmap");

   property p_hold_last;
      @(posedge hclk) disable iff (!hresetn)
      state_q == failsafe_pkg::ST_SAFE && act_type_q == failsafe_pkg::TYPE_HOLD
         |=> $stable(point_out);
   endproperty
   a_hold_last: assert property (p_hold_last)
      else $error("hold fail safe changed an output");

   property p_normal_follow;
      @(posedge hclk) disable iff (!hresetn)
      state_q != failsafe_pkg::ST_SAFE |=> point_out == $past(output_q);
   endproperty
   a_normal_follow: assert property (p_normal_follow)
      else $error("outputs not following host value outside fail safe");

   property p_byte_two;
      @(posedge hclk) disable iff (!hresetn)
      wr_output && req_q.lanes[2]
         |=> output_q[23:16] == $past(hwdata[23:16])
             && ($past(req_q.lanes[1:0]) != 2'b00 || output_q[15:0] == $past(output_q[15:0]));
   endproperty
   a_byte_two: assert property (p_byte_two)
      else $error("byte offset 2 did not land on points 16 to 23");

   property p_word_one;
      @(posedge hclk) disable iff (!hresetn)
      wr_bitmap && req_q.lanes[2] |=> stage_bitmap_q[16] == $past(hwdata[16]);
   endproperty
   a_word_one: assert property (p_word_one)
      else $error("word offset 1 did not start at point 16");

endmodule : failsafe_outputs

// File: sim/host_link_model.sv
// Purpose: Far-side host whose traffic keeps the bank's link pin healthy
// Assumes: Host silence is commanded by the bench
// Notes:   Pin moves a few ns off the clock edge, as a real async pin would
`timescale 1ns/1ns
module host_link_model #(
   parameter int unsigned SKEW_NS = 3
) (
   input  wire logic hclk,         // Bus clock, times the pin change
   input  wire logic host_silent,  // High while the host stops talking
   output logic      link_alive    // Healthy-link pin to the bank
);
   // Skewed update so the bank's synchroniser sees a truly late edge
   initial link_alive = 1'b1;
   always @(posedge hclk) link_alive <= #(SKEW_NS) ~host_silent;
endmodule : host_link_model

// File: sim/tb.sv
// Purpose: Self-checking bench for the fail safe output bank
// Assumes: Word-only AHB-Lite master, tenth of a second shortened to 10 cycles
// Notes:   Random outputs and bitmaps from a fixed seed, delay corners 0 and 255
`timescale 1ns/1ns
module tb;
   localparam int unsigned TC = 10;  // Short tenth so a 255 delay fits the run
   logic                            hclk;
   logic                            hresetn;
   logic                            hsel;
   logic [31:0]                     haddr;
   logic [1:0]                      htrans;
   logic                            hwrite;
   logic [2:0]                      hsize;
   logic [31:0]                     hwdata;
   logic [31:0]                     hrdata;
   logic                            hreadyout;
   logic                            hresp;
   logic                            link_alive;
   logic                            host_silent;
   logic [failsafe_pkg::POINTS-1:0] point_out;
   logic [31:0]                     rd;
   logic [31:0]                     v;
   logic [7:0]                      act_ty;
   logic [7:0]                      act_d;
   logic [7:0]                      ty_tab [8];
   logic [7:0]                      d_tab [8];
   int                              fails;
   int                              checks_done;
   integer                          seed;

   failsafe_outputs #(.TENTH_CYCLES(TC)) failsafe_outputs_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link_alive(link_alive), .point_out(point_out));

   host_link_model host_link_model_inst (
      .hclk(hclk), .host_silent(host_silent), .link_alive(link_alive));

   // Free-running 125 MHz clock
   initial begin
      forever #4 hclk = ~hclk;
   end

   // Expected status word: delay, type, alive bit, supervision state
   function automatic logic [31:0] status_exp(input logic [1:0] st, input logic al,
                                              input logic [7:0] ty, input logic [7:0] d);
      return {6'h00, st, 7'h00, al, ty, d};
   endfunction : status_exp

   // Expected points once fail safe is in force; unknown codes hold
   function automatic logic [23:0] safe_val(input logic [7:0] ty, input logic [23:0] o,
                                            input logic [23:0] b);
      if (ty == failsafe_pkg::TYPE_OFF) return 24'h000000;
      if (ty == failsafe_pkg::TYPE_PATTERN) return b;
      return o;
   endfunction : safe_val

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up

   // One word transfer; hold each phase until hready is sampled high.
   // No local limit: a hung slave is caught by the watchdog alone.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      hsize <= 3'h2;
      do begin @(posedge hclk); end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin @(posedge hclk); end while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      bus(1'b1, a, wd);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rdc

   // Commit a config, drop the link, check timing, action and recovery
   task automatic run_loss(input logic [7:0] ty, input logic [7:0] d);
      logic [23:0] o, b, o2, e;
      o = 24'($random(seed));
      b = 24'($random(seed));
      o2 = 24'($random(seed));
      e = safe_val(ty, o, b);
      wr(failsafe_pkg::OFF_OUTPUT, {8'h00, o});
      wr(failsafe_pkg::OFF_BITMAP, {8'h00, b});
      wr(failsafe_pkg::OFF_SELECT, {24'h000000, ty});
      wr(failsafe_pkg::OFF_DELAY, {24'h000000, d});
      rdc(failsafe_pkg::OFF_STATUS, status_exp(2'h0, 1'b1, act_ty, act_d));
      wr(failsafe_pkg::OFF_COMMIT, 32'h0000_0000);
      rdc(failsafe_pkg::OFF_STATUS, status_exp(2'h0, 1'b1, act_ty, act_d));
      wr(failsafe_pkg::OFF_COMMIT, 32'h0000_0001);
      rdc(failsafe_pkg::OFF_COMMIT, 32'h0000_0000);
      rdc(failsafe_pkg::OFF_STATUS, status_exp(2'h0, 1'b1, ty, d));
      act_ty = ty;
      act_d = d;
      // Staged only: this bitmap must not reach the safe outputs
      wr(failsafe_pkg::OFF_BITMAP, {8'h00, ~b});
      host_silent <= 1'b1;
      if (d != 8'h00) begin
         repeat (int'(d) * TC) @(posedge hclk);
         check({8'h00, point_out}, {8'h00, o});
      end
      repeat (12) @(posedge hclk);
      check({8'h00, point_out}, {8'h00, e});
      rdc(failsafe_pkg::OFF_STATUS, status_exp(2'h2, 1'b0, ty, d));
      // Writes while safe are stored but must not move the points
      wr(failsafe_pkg::OFF_OUTPUT, {8'h00, o2});
      repeat (2) @(posedge hclk);
      check({8'h00, point_out}, {8'h00, e});
      host_silent <= 1'b0;
      repeat (10) @(posedge hclk);
      check({8'h00, point_out}, {8'h00, o2});
      rdc(failsafe_pkg::OFF_STATUS, status_exp(2'h0, 1'b1, ty, d));
   endtask : run_loss

   // Hang guard, far beyond the longest expected run
   initial begin
      repeat (40000) @(posedge hclk);
      fails++;
      $display("FAIL t=%0t watchdog expired", $time);
      wrap_up();
   end

   // Main sequence
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      host_silent = 1'b0;
      fails = 0;
      checks_done = 0;
      seed = 32'h1253AEE3;
      act_ty = failsafe_pkg::TYPE_OFF;
      act_d = 8'h00;
      // Last entry is an unknown type code, which must hold the last state
      ty_tab = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h01, 8'h03, 8'h02, 8'h00};
      d_tab = '{8'h00, 8'h03, 8'h02, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h02};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({8'h00, point_out}, 32'h0000_0000);
      rdc(failsafe_pkg::OFF_OUTPUT, 32'h0000_0000);
      rdc(failsafe_pkg::OFF_STATUS, status_exp(2'h0, 1'b1, act_ty, act_d));
      rdc(failsafe_pkg::OFF_BITMAP, 32'h0000_0000);
      rdc(8'h18, 32'h0000_0000);
      check({31'h0, hresp}, 32'h0000_0000);
      // Word writes: bit i drives point i, top byte dropped
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         if (i == 0) v = 32'hFF01_0000;
         if (i == 1) v = 32'h00FF_0000;
         wr(failsafe_pkg::OFF_OUTPUT, v);
         rdc(failsafe_pkg::OFF_OUTPUT, {8'h00, v[23:0]});
         check({8'h00, point_out}, {8'h00, v[23:0]});
      end
      for (int i = 0; i < 8; i++) begin
         run_loss(ty_tab[i], d_tab[i]);
      end
      wrap_up();
   end
endmodule : tb
